// ===== rtl/code_window_pkg.sv
/*
  Shared constants and carriers for the code-space data window: the register map,
  field positions, reset values, the load-kind encoding and the request record.
  Assumes one clock (pclk) and one active-low asynchronous reset (presetn).
*/
package code_window_pkg;

  // ****************************************
  // register map, byte addresses on apb
  // ****************************************
  localparam logic [7:0] PAGE_OFS = 8'h00;
  localparam logic [7:0] CORE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ENABLE_BIT = 2;
  localparam int PAGE_W = 8;
  localparam int WIN_BIT = 15;
  localparam int OFS_W = 15;
  localparam int PM_ADDR_W = 23;
  localparam int PM_WORD_W = 24;
  localparam int DATA_W = 16;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic ENABLE_RESET = 1'b0;
  localparam int ST_EXTRA_LSB = 0;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_CODE_BIT = 3;
  localparam int ST_COUNT_LSB = 16;

  // ****************************************
  // timing counts, in instruction cycles
  // ****************************************
  localparam logic [1:0] EXTRA_NONE = 2'h0;
  localparam logic [1:0] EXTRA_MOVE = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  localparam logic [1:0] EXTRA_REPEAT_EDGE = 2'h2;

  // ****************************************
  // load kinds and request record
  // ****************************************
  typedef enum logic [1:0] {
    KIND_MOVE_WORD,
    KIND_MOVE_DOUBLE,
    KIND_OTHER
  } load_kind_type;

  typedef struct packed {
    logic [DATA_W-1:0] addr;
    load_kind_type kind;
    logic in_repeat;
    logic rpt_first;
    logic rpt_last;
    logic rpt_irq_exit;
    logic rpt_irq_reenter;
  } load_req_type;

endpackage : code_window_pkg

// ===== rtl/window_decode.sv
/*
  Combinational address decode of the code window: routing decision and the
  program and data addresses. Assumes its inputs are stable within a cycle.
*/
`timescale 1ns/100ps
module window_decode
  import code_window_pkg::*;
(
  input wire logic [DATA_W-1:0] addr,
  input wire logic window_enable,
  input wire logic table_active,
  input wire logic [PAGE_W-1:0] page,
  output logic hit,
  output logic [PM_ADDR_W-1:0] pm_addr,
  output logic [DATA_W-1:0] dm_addr
);

  // table transfers own the program bus, so the window steps aside
  assign hit = addr[WIN_BIT] & window_enable & ~table_active;
  // word addresses step by two, so the offset goes across unshifted
  assign pm_addr = {page, addr[OFS_W-1:0]};
  assign dm_addr = addr;

endmodule : window_decode

// ===== rtl/stall_counter.sv
/*
  Down counter for the extra instruction cycles of one load.
  Assumes load is a one-cycle pulse issued only while the counter is idle.
*/
`timescale 1ns/100ps
module stall_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [1:0] load_val,
  output logic zero
);

  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;

  assign nxt_cnt = load ? load_val : (cnt_ff != 2'h0 ? cnt_ff - 2'h1 : 2'h0);
  assign zero = (cnt_ff == 2'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : stall_counter

// ===== rtl/code_window.sv
/*
  Code-space data window: loads with address bit 15 set, while the window is enabled
  and no table transfer runs, are served from a page of program memory, others from
  data memory, with their extra stall cycles.
  Holds the apb register file (page select, core control, status).
  Assumes a core load port on pclk, and program and data memories that return
  read data in the cycle after their request strobe.
*/
// Summary of operation
// - window read only when address bit 15 is one and enable set
// - window enable sits at bit 2 of the core control register
// - upper 32 KB of data space maps onto one 16K-word program page
// - 8-bit page select register picks one of 256 pages
// - program address is page concatenated with low 15 address bits
// - low 15 data address bits pass unshifted to program address
// - return low 16 bits of the program word, drop upper 8
// - a window read issues one program fetch and no data memory read
// - window access disabled while a table read or write runs
// - outside repeat loops, word and double moves take one extra cycle
// - outside repeat loops, all other window reads take two extra cycles
// - in repeat: first, last, interrupt exit, re-entry take two extra
// - other repeat iterations complete the window read with no extra cycle
`timescale 1ns/100ps
module code_window
  import code_window_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ld_valid,
  input wire load_req_type ld_req,
  output logic ld_ready,
  output logic ld_done,
  output logic [DATA_W-1:0] ld_rdata,
  input wire logic table_active,
  output logic pm_req,
  output logic [PM_ADDR_W-1:0] pm_addr,
  input wire logic [PM_WORD_W-1:0] pm_rdata,
  output logic dm_req,
  output logic [DATA_W-1:0] dm_addr,
  input wire logic [DATA_W-1:0] dm_rdata
);

  // ****************************************
  // extra cycle table
  // ****************************************
  function automatic logic [1:0] extra_cycles(input logic hit, input load_req_type r);
    logic edge_iter;
    edge_iter = r.rpt_first | r.rpt_last | r.rpt_irq_exit | r.rpt_irq_reenter;
    if (!hit) begin
      extra_cycles = EXTRA_NONE;
    end else if (r.in_repeat) begin
      extra_cycles = edge_iter ? EXTRA_REPEAT_EDGE : EXTRA_NONE;
    end else if (r.kind == KIND_MOVE_WORD || r.kind == KIND_MOVE_DOUBLE) begin
      extra_cycles = EXTRA_MOVE;
    end else begin
      extra_cycles = EXTRA_OTHER;
    end
  endfunction : extra_cycles

  // ****************************************
  // register file
  // ****************************************
  logic [PAGE_W-1:0] page_ff;
  logic enable_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [1:0] last_extra_ff;
  logic last_code_ff;
  logic [15:0] win_count_ff;
  wire setup = psel & ~penable;
  wire wr_take = psel & penable & pwrite;
  wire page_sel = (paddr[7:0] == PAGE_OFS) && (paddr[31:8] == 24'h000000);
  wire core_sel = (paddr[7:0] == CORE_OFS) && (paddr[31:8] == 24'h000000);
  wire stat_sel = (paddr[7:0] == STATUS_OFS) && (paddr[31:8] == 24'h000000);
  wire mapped = page_sel | core_sel | (stat_sel & ~pwrite);
  wire busy;
  wire [31:0] status_word;
  wire [31:0] rd_mux;

  assign status_word = {win_count_ff, 12'h000, last_code_ff, busy, last_extra_ff};
  assign rd_mux = page_sel ? {24'h000000, page_ff} :
                  core_sel ? {29'h00000000, enable_ff, 2'h0} :
                  stat_sel ? status_word : 32'h00000000;
  // zero wait states; read data is latched in the setup cycle
  assign pready = psel & penable;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff & psel & penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h00000000 : rd_mux;
      pslverr_ff <= ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_ff <= PAGE_RESET;
      enable_ff <= ENABLE_RESET;
    end else if (wr_take) begin
      if (page_sel) begin
        page_ff <= pwdata[PAGE_W-1:0];
      end
      if (core_sel) begin
        enable_ff <= pwdata[ENABLE_BIT];
      end
    end
  end

  // ****************************************
  // address decode and stall count
  // ****************************************
  wire hit;
  wire [PM_ADDR_W-1:0] pm_addr_c;
  wire [DATA_W-1:0] dm_addr_c;
  wire cnt_zero;
  wire [1:0] extra_c;

  window_decode u_decode (
    .addr(ld_req.addr),
    .window_enable(enable_ff),
    .table_active(table_active),
    .page(page_ff),
    .hit(hit),
    .pm_addr(pm_addr_c),
    .dm_addr(dm_addr_c)
  );

  assign extra_c = extra_cycles(hit, ld_req);

  // ****************************************
  // load sequencer
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_CAPTURE,
    ST_STALL,
    ST_DONE
  } seq_state_type;

  seq_state_type state_ff;
  seq_state_type nxt_state;
  logic code_ff;
  logic pm_req_ff;
  logic dm_req_ff;
  logic [PM_ADDR_W-1:0] pm_addr_ff;
  logic [DATA_W-1:0] dm_addr_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic done_ff;
  wire accept = ld_valid & ld_ready;
  wire leave_capture;
  wire in_capture = (state_ff == ST_CAPTURE);
  wire in_stall = (state_ff == ST_STALL);
  wire stall_load;
  wire [1:0] stall_val;

  stall_counter u_stall (
    .pclk(pclk),
    .presetn(presetn),
    .load(stall_load),
    .load_val(stall_val),
    .zero(cnt_zero)
  );

  // count starts once the word is in, so every extra cycle is a real stall;
  // loading it at accept would hide the extra cycles behind the fetch
  assign stall_load = in_capture & (last_extra_ff != EXTRA_NONE);
  assign stall_val = last_extra_ff - 2'h1;
  assign leave_capture = (in_capture & ~stall_load) | (in_stall & cnt_zero);
  assign ld_ready = (state_ff == ST_IDLE);
  assign busy = ~ld_ready;
  assign ld_done = done_ff;
  assign ld_rdata = rdata_ff;
  assign pm_req = pm_req_ff;
  assign pm_addr = pm_addr_ff;
  assign dm_req = dm_req_ff;
  assign dm_addr = dm_addr_ff;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (accept) begin
          nxt_state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        nxt_state = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        if (leave_capture) begin
          nxt_state = ST_DONE;
        end else begin
          nxt_state = ST_STALL;
        end
      end
      ST_STALL: begin
        if (leave_capture) begin
          nxt_state = ST_DONE;
        end
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_ff <= 1'b0;
      pm_req_ff <= 1'b0;
      dm_req_ff <= 1'b0;
      pm_addr_ff <= '0;
      dm_addr_ff <= '0;
    end else begin
      pm_req_ff <= accept & hit;
      dm_req_ff <= accept & ~hit;
      if (accept) begin
        code_ff <= hit;
        pm_addr_ff <= pm_addr_c;
        dm_addr_ff <= dm_addr_c;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= leave_capture;
      if (state_ff == ST_CAPTURE) begin
        // upper byte of the program word is opcode space, never data
        rdata_ff <= code_ff ? pm_rdata[DATA_W-1:0] : dm_rdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_extra_ff <= 2'h0;
      last_code_ff <= 1'b0;
      win_count_ff <= 16'h0000;
    end else if (accept) begin
      last_extra_ff <= extra_c;
      last_code_ff <= hit;
      win_count_ff <= win_count_ff + {15'h0000, hit};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire take_code = accept & hit;
  wire plain_move = ~ld_req.in_repeat &
    (ld_req.kind == KIND_MOVE_WORD || ld_req.kind == KIND_MOVE_DOUBLE);
  wire rpt_edge = ld_req.in_repeat & (ld_req.rpt_first | ld_req.rpt_last |
    ld_req.rpt_irq_exit | ld_req.rpt_irq_reenter);

  sequence one_done_then_ready;
    ld_done ##1 (!ld_done && ld_ready);
  endsequence

  sequence done_at3;
    !ld_done ##1 !ld_done ##1 ld_done;
  endsequence

  sequence done_at4;
    !ld_done ##1 !ld_done ##1 !ld_done ##1 ld_done;
  endsequence

  sequence done_at5;
    !ld_done ##1 !ld_done ##1 !ld_done ##1 !ld_done ##1 ld_done;
  endsequence

  route_gate_a: assert property (pm_req |->
    $past(ld_req.addr[WIN_BIT] && enable_ff && !table_active))
    else $error("program fetch without window address or enable");
  enable_bit_a: assert property (wr_take && core_sel |=>
    enable_ff == $past(pwdata[ENABLE_BIT]))
    else $error("window enable not taken from bit 2");
  page_write_a: assert property (wr_take && page_sel |=> page_ff == $past(pwdata[7:0]))
    else $error("page select write lost");
  addr_form_a: assert property (take_code |=> pm_req && pm_addr == {$past(page_ff),
    $past(ld_req.addr[OFS_W-1:0])})
    else $error("program address not page and offset");
  low_half_a: assert property (take_code ##2 1'b1 |=>
    rdata_ff == $past(pm_rdata[DATA_W-1:0]))
    else $error("window data not low half of program word");
  table_block_a: assert property (table_active && accept |=> !pm_req)
    else $error("window used during table transfer");
  move_extra_a: assert property (take_code && plain_move |-> ##1 done_at4)
    else $error("move through window not one extra cycle");
  other_extra_a: assert property (take_code && !ld_req.in_repeat && !plain_move
    |-> ##1 done_at5)
    else $error("other window read not two extra cycles");
  repeat_edge_a: assert property (take_code && rpt_edge |-> ##1 done_at5)
    else $error("repeat edge iteration not two extra cycles");
  repeat_mid_a: assert property (take_code && ld_req.in_repeat && !rpt_edge
    |-> ##1 done_at3)
    else $error("repeat middle iteration stalled");
  plain_data_a: assert property (accept && !hit |=>
    dm_req && !pm_req ##1 !ld_done ##1 ld_done)
    else $error("data memory read took extra cycles");
  done_pulse_a: assert property (ld_done |-> one_done_then_ready)
    else $error("load done not a single pulse before ready");
  ready_hold_a: assert property (accept |=> !ld_ready ##1 !ld_ready ##1 !ld_ready)
    else $error("new load taken before the window read finished");
  data_word_a: assert property (dm_req |-> ##2 ld_rdata == $past(dm_rdata))
    else $error("data memory word not returned");
  page_hold_a: assert property (pm_req |-> pm_addr[PM_ADDR_W-1:OFS_W] == $past(page_ff))
    else $error("program page not taken from page select");
  data_route_a: assert property (dm_req |->
    $past(!ld_req.addr[WIN_BIT] || !enable_ff || table_active))
    else $error("data memory read of a window address");
  window_off_a: assert property (accept && !enable_ff |=> dm_req && !pm_req)
    else $error("window used while disabled");
  table_data_a: assert property (accept && table_active |=> dm_req)
    else $error("table transfer did not force data memory");

endmodule : code_window

// ===== verif/mem_model.sv
/*
  Program and data memory model on the far side of the code window.
  Assumes request strobes are one-cycle pulses on pclk.
*/
`timescale 1ns/100ps
module mem_model
  import code_window_pkg::*;
(
  input wire logic pclk,
  input wire logic pm_req,
  input wire logic [PM_ADDR_W-1:0] pm_addr,
  output logic [PM_WORD_W-1:0] pm_rdata,
  input wire logic dm_req,
  input wire logic [DATA_W-1:0] dm_addr,
  output logic [DATA_W-1:0] dm_rdata
);
  // ****************************************
  // answer one cycle after the strobe
  // ****************************************
  initial begin
    pm_rdata = '0;
    dm_rdata = '0;
  end
  // idle cycles invert the bus so stale data never passes for valid
  always @(posedge pclk) begin
    pm_rdata <= pm_req ? {pm_addr[7:0] ^ 8'hC3, pm_addr[15:0] ^ {pm_addr[22:15], 8'h96}}
                       : ~pm_rdata;
    dm_rdata <= dm_req ? (dm_addr ^ 16'h3C5A) : ~dm_rdata;
  end
endmodule : mem_model

// ===== verif/code_window_tb.sv
/*
  Self-checking bench of the code window: apb register checks, directed
  timing cases and random loads against a behavioural model.
  Assumes mem_model answers memory strobes one cycle later.
*/
`timescale 1ns/100ps
module code_window_tb
  import code_window_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic ld_valid, ld_ready, ld_done, table_active, pm_req, dm_req, er;
  load_req_type ld_req, r;
  logic [DATA_W-1:0] ld_rdata, dm_addr, dm_rdata, last_dm, cnt_m;
  logic [PM_ADDR_W-1:0] pm_addr, last_pm;
  logic [PM_WORD_W-1:0] pm_rdata;
  logic [7:0] page_m;
  logic en_m, last_win;
  logic [1:0] last_extra;
  int bad_count, n_compared, pm_n, dm_n, cyc;

  code_window code_window_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ld_valid(ld_valid),
    .ld_req(ld_req), .ld_ready(ld_ready), .ld_done(ld_done), .ld_rdata(ld_rdata),
    .table_active(table_active), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_addr(dm_addr), .dm_rdata(dm_rdata));
  mem_model mem_model_i (.pclk(pclk), .pm_req(pm_req), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_addr(dm_addr), .dm_rdata(dm_rdata));

  always #10 pclk = ~pclk;

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // loads take a few cycles each; this ceiling only catches a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end

  always @(negedge pclk) begin
    if (pm_req === 1'b1) begin
      pm_n++;
      last_pm = pm_addr;
    end
    if (dm_req === 1'b1) begin
      dm_n++;
      last_dm = dm_addr;
    end
  end

  // ****************************************
  // bus and load drivers
  // ****************************************
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && !er && a == {24'h0, PAGE_OFS}) page_m = d[7:0];
    if (w && !er && a == {24'h0, CORE_OFS}) en_m = d[ENABLE_BIT];
  endtask : apb

  task automatic do_load(input load_req_type q, input logic tact);
    int n, extra;
    logic win;
    logic [15:0] exp;
    win = q.addr[WIN_BIT] & en_m & ~tact;
    extra = !win ? 0 : q.in_repeat ?
      ((q.rpt_first | q.rpt_last | q.rpt_irq_exit | q.rpt_irq_reenter) ? 2 : 0) :
      (q.kind == KIND_OTHER ? 2 : 1);
    exp = win ? ({page_m[0], q.addr[14:0]} ^ {page_m, 8'h96}) : (q.addr ^ 16'h3C5A);
    @(posedge pclk);
    ld_valid <= 1'b1;
    ld_req <= q;
    table_active <= tact;
    do @(negedge pclk); while (ld_ready !== 1'b1);
    @(posedge pclk);
    ld_valid <= 1'b0;
    n = 0;
    pm_n = 0;
    dm_n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (ld_done !== 1'b1 && n < 20);
    check(n, 3 + extra);
    check(ld_rdata, exp);
    check(pm_n, win);
    check(dm_n, !win);
    if (win) check(last_pm, {page_m, q.addr[14:0]});
    else check(last_dm, q.addr);
    cnt_m = cnt_m + win;
    last_win = win;
    last_extra = extra[1:0];
  endtask : do_load

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, ld_valid, table_active} = '0;
    paddr = '0;
    pwdata = '0;
    ld_req = '0;
    {bad_count, n_compared, cyc} = '0;
    {cnt_m, last_win, last_extra, en_m} = '0;
    page_m = PAGE_RESET;
    void'($urandom(32'h6d4e27c2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, {24'h0, PAGE_OFS}, 0);
    check(rd, {24'h0, PAGE_RESET});
    apb(0, {24'h0, CORE_OFS}, 0);
    check(rd, {29'h0, ENABLE_RESET, 2'h0});
    apb(0, {24'h0, STATUS_OFS}, 0);
    check(rd, 32'h0);
    apb(1, {24'h0, PAGE_OFS}, 32'hFFFF_FFFF);
    apb(0, {24'h0, PAGE_OFS}, 0);
    check(rd, 32'h0000_00FF);
    apb(1, {24'h0, CORE_OFS}, 32'hFFFF_FFFF);
    apb(0, {24'h0, CORE_OFS}, 0);
    check(rd, 32'h0000_0004);
    apb(0, 32'h0000_000C, 0);
    check({rd[30:0], er}, 32'h1);
    apb(1, {24'h0, STATUS_OFS}, 32'h5);
    check(er, 1'b1);
    // every kind outside repeat, every repeat edge, then a middle iteration
    for (int j = 0; j < 8; j++) begin
      r = '0;
      r.addr = 16'h8000 | j[15:0];
      r.kind = load_kind_type'(j % 3);
      r.in_repeat = (j >= 3);
      if (j >= 3 && j < 7) {r.rpt_first, r.rpt_last, r.rpt_irq_exit, r.rpt_irq_reenter}
        = 4'h8 >> (j - 3);
      do_load(r, 1'b0);
    end
    for (int i = 0; i < 60; i++) begin
      if (i % 6 == 0) begin
        apb(1, {24'h0, PAGE_OFS}, $urandom);
        apb(1, {24'h0, CORE_OFS}, $urandom);
      end
      r.addr = 16'($urandom);
      r.kind = load_kind_type'($urandom_range(2));
      {r.in_repeat, r.rpt_first, r.rpt_last, r.rpt_irq_exit, r.rpt_irq_reenter} = 5'($urandom);
      do_load(r, $urandom_range(3) == 0);
    end
    apb(0, {24'h0, STATUS_OFS}, 0);
    check(rd, {cnt_m, 12'h0, last_win, 1'b0, last_extra});
    complete_run();
  end
endmodule : code_window_tb
